/* File: design/lfu_top.sv */
// lfu_top: uart with lin break and sync framing, apb register slave
// assumes 8n1 characters and a host that keeps flow control off
`timescale 1ns/1ps
module lfu_top #(
  parameter int QW = 5
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire lfu_pkg::lfu_apb_req_t apb_req,
  output      lfu_pkg::lfu_apb_rsp_t apb_rsp,
  input  wire logic              rxd,
  output      logic              txd
);
  import lfu_pkg::*;

  typedef struct packed {
    logic        lin;
    logic        resp_ok;
    logic [31:0] baud;
    logic [15:0] div;
    logic [7:0]  txq_wp, txq_rp;
    logic [7:0]  tx_len;
    lfu_txst_t   txst;
    logic [15:0] txcnt;
    logic [3:0]  txbit;
    logic [9:0]  txsh;
    logic        txd;
    logic [15:0] rxcnt;
    logic [3:0]  rxbit;
    logic [7:0]  rxsh;
    logic        rxbusy;
    logic [4:0]  lowbits;
    lfu_rxst_t   rxst;
    logic [7:0]  rxbyte;
    logic        rxvalid;
    logic        rxovr;
    logic        brk_seen;
    logic [31:0] prdata;
    logic        pslverr;
    logic        pend;
  } lfu_st_t;

  lfu_st_t     q, d;
  logic [7:0]  txq_mem [0:(1<<QW)-1];
  logic        acc, wr, rd, q_full, q_empty, push;
  logic [7:0]  rx_char;
  logic        rx_done;
  logic        rx_new;

  assign acc     = apb_req.psel && apb_req.penable;
  // one wait state: reads load prdata first so it stands with pready, writes land then
  assign wr      = acc && apb_req.pwrite && q.pend;
  assign rd      = acc && !apb_req.pwrite && !q.pend;
  assign q_empty = (q.txq_wp == q.txq_rp);
  assign q_full  = ((q.txq_wp - q.txq_rp) == 8'(1 << QW));
  assign push    = wr && apb_req.paddr == LFU_OFS_TXDATA && !q_full;

  always_ff @(posedge clk) begin
    if (push) begin
      txq_mem[q.txq_wp[QW-1:0]] <= apb_req.pwdata[7:0];
    end
  end

  always_comb begin
    d       = q;
    rx_done = 1'b0;
    rx_new  = 1'b0;  // a byte handed to the host this cycle
    d.pend  = acc && !q.pend;
    rx_char = q.rxsh;
    d.div   = 16'(LFU_CLK_HZ / ((q.baud == 32'h0) ? 1 : q.baud));

    // transmitter
    unique case (q.txst)
      LFU_TX_IDLE: begin
        d.txd = 1'b1;
        if (q.tx_len != 8'h0 && !q_empty) begin
          if (q.lin) begin
            d.txst  = LFU_TX_BREAK;
            d.txbit = 4'(LFU_BRK_BITS - 1);
            d.txcnt = 16'h0;
            d.txd   = 1'b0;
          end else begin
            d.txst = LFU_TX_DATA;
            d.txsh = {1'b1, txq_mem[q.txq_rp[QW-1:0]], 1'b0};
            d.txq_rp = q.txq_rp + 8'h1;
            d.tx_len = q.tx_len - 8'h1;
            d.txbit = 4'd9;
            d.txcnt = 16'h0;
            d.txd   = 1'b0;
          end
        end
      end
      LFU_TX_BREAK: begin
        d.txd = 1'b0;
        d.txcnt = q.txcnt + 16'h1;
        if (q.txcnt + 16'h1 >= q.div) begin
          d.txcnt = 16'h0;
          if (q.txbit == 4'h0) begin
            d.txst = LFU_TX_DELIM;
            d.txd  = 1'b1;
          end else begin
            d.txbit = q.txbit - 4'h1;
          end
        end
      end
      LFU_TX_DELIM: begin
        d.txcnt = q.txcnt + 16'h1;
        if (q.txcnt + 16'h1 >= q.div) begin
          d.txst  = LFU_TX_SYNC;
          d.txsh  = {1'b1, LFU_SYNC_BYTE, 1'b0};
          d.txbit = 4'd9;
          d.txcnt = 16'h0;
          d.txd   = 1'b0;
        end
      end
      LFU_TX_SYNC, LFU_TX_DATA: begin
        d.txcnt = q.txcnt + 16'h1;
        if (q.txcnt + 16'h1 >= q.div) begin
          d.txcnt = 16'h0;
          if (q.txbit == 4'h0) begin
            if (q.tx_len != 8'h0 && !q_empty) begin
              d.txst   = LFU_TX_DATA;
              d.txsh   = {1'b1, txq_mem[q.txq_rp[QW-1:0]], 1'b0};
              d.txq_rp = q.txq_rp + 8'h1;
              d.tx_len = q.tx_len - 8'h1;
              d.txbit  = 4'd9;
              d.txd    = 1'b0;
            end else begin
              d.txst = LFU_TX_IDLE;
              d.txd  = 1'b1;
            end
          end else begin
            d.txbit = q.txbit - 4'h1;
            d.txsh  = {1'b1, q.txsh[9:1]};
            d.txd   = q.txsh[1];
          end
        end
      end
    endcase

    // receiver, 8n1, samples mid bit
    if (!q.rxbusy) begin
      if (!rxd) begin
        d.rxbusy  = 1'b1;
        d.rxcnt   = {1'b0, q.div[15:1]};
        d.rxbit   = 4'd0;
        d.lowbits = 5'h0;
      end
    end else begin
      d.rxcnt = q.rxcnt + 16'h1;
      if (q.rxcnt + 16'h1 >= q.div) begin
        d.rxcnt = 16'h0;
        d.rxbit = q.rxbit + 4'h1;
        if (!rxd) begin
          d.lowbits = q.lowbits + 5'h1;
        end else begin
          d.lowbits = 5'h0;
        end
        if (q.rxbit >= 4'd1 && q.rxbit <= 4'd8) begin
          d.rxsh = {rxd, q.rxsh[7:1]};
        end
        // a long low run is a break, not a character; wait for idle
        if (q.rxbit >= 4'd9 && rxd) begin
          d.rxbusy = 1'b0;
          if (q.rxbit == 4'd9) begin
            rx_done = 1'b1;
          end
        end
        if (q.rxbit == 4'd15) begin
          d.rxbit = 4'd15;
        end
        if (q.lowbits + 5'h1 >= 5'(LFU_BRK_RXMIN) && !rxd) begin
          d.brk_seen = 1'b1;
        end
      end
    end

    if (!d.rxbusy && q.rxbusy && q.brk_seen) begin
      d.brk_seen = 1'b0;
      if (q.lin) begin
        d.rxst = LFU_RX_SYNC;
      end
    end

    if (rx_done) begin
      unique case (q.rxst)
        LFU_RX_NORM, LFU_RX_PASS: begin
          rx_new    = 1'b1;
          d.rxovr   = q.rxovr | q.rxvalid;
          d.rxvalid = 1'b1;
          d.rxbyte  = rx_char;
        end
        LFU_RX_SYNC: begin
          // sync dropped; anything else means no lin frame start
          d.rxst = LFU_RX_PASS;
          if (rx_char != LFU_SYNC_BYTE) begin
            rx_new    = 1'b1;
            d.rxovr   = q.rxovr | q.rxvalid;
            d.rxvalid = 1'b1;
            d.rxbyte  = rx_char;
          end
        end
        default: d.rxst = LFU_RX_NORM;
      endcase
    end

    // apb slave, one wait state
    d.pslverr = 1'b0;
    if (wr) begin
      unique case (apb_req.paddr)
        LFU_OFS_CMD: begin
          if (apb_req.pwdata[15:0] == LFU_CMD_LIN) begin
            d.lin     = 1'b1;
            d.resp_ok = 1'b1;
          end
        end
        LFU_OFS_BAUD:   d.baud = apb_req.pwdata;
        LFU_OFS_TXDATA: d.pslverr = q_full;
        LFU_OFS_TXCTL: begin
          if (q.txst == LFU_TX_IDLE) begin
            d.tx_len = apb_req.pwdata[7:0];
          end else begin
            d.pslverr = 1'b1;
          end
        end
        LFU_OFS_STATUS: d.rxovr = rx_new && q.rxvalid;  // a fresh overrun beats the clear
        default: d.pslverr = 1'b1;
      endcase
      if (push) begin
        d.txq_wp = q.txq_wp + 8'h1;
      end
    end
    if (rd) begin
      unique case (apb_req.paddr)
        LFU_OFS_CMD:    d.prdata = {31'h0, q.lin};
        LFU_OFS_RESP0:  d.prdata = q.resp_ok ? LFU_RESP0_VAL : 32'h0;
        LFU_OFS_RESP1:  d.prdata = q.resp_ok ? LFU_RESP1_VAL : 32'h0;
        LFU_OFS_BAUD:   d.prdata = q.baud;
        LFU_OFS_TXCTL:  d.prdata = {24'h0, q.tx_len};
        LFU_OFS_RXDATA: begin
          d.prdata = {23'h0, q.rxvalid, q.rxbyte};
          if (!rx_new) begin
            d.rxvalid = 1'b0;  // a new byte in the same cycle wins
          end
        end
        LFU_OFS_STATUS: d.prdata = {26'h0, q.rxovr, q.rxvalid, q_full, q_empty,
                                    q.txst != LFU_TX_IDLE, q.lin};
        default: begin
          d.prdata  = 32'h0;
          d.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q        <= '0;
      q.baud   <= LFU_BAUD_RST;
      q.div    <= 16'h1;
      q.txd    <= 1'b1;
      q.txst   <= LFU_TX_IDLE;
      q.rxst   <= LFU_RX_NORM;
    end else begin
      q <= d;
    end
  end

  assign txd     = q.txd;
  assign apb_rsp = '{prdata:  q.prdata,
                     pready:  q.pend,
                     pslverr: q.pend && (apb_req.pwrite ? d.pslverr : q.pslverr)};

  // all checks run on clk; the request is held by the master through the wait state
  a_break_low: assert property (@(posedge clk) disable iff (!arst_n)
    q.txst == LFU_TX_BREAK |-> !txd) else $error("break not low");

  a_lin_break_first: assert property (@(posedge clk) disable iff (!arst_n)
    q.lin && q.txst == LFU_TX_IDLE && d.txst != LFU_TX_IDLE |=> q.txst == LFU_TX_BREAK)
    else $error("lin frame without break");

  a_plain_no_break: assert property (@(posedge clk) disable iff (!arst_n)
    !q.lin |-> q.txst != LFU_TX_BREAK && q.rxst == LFU_RX_NORM)
    else $error("lin framing while plain");

  a_delim_high: assert property (@(posedge clk) disable iff (!arst_n)
    q.txst == LFU_TX_DELIM |-> txd) else $error("delimiter not high");

  a_sync_after_brk: assert property (@(posedge clk) disable iff (!arst_n)
    q.txst == LFU_TX_DELIM && d.txst != LFU_TX_DELIM |=> q.txst == LFU_TX_SYNC && !txd)
    else $error("sync not after break");

  a_frame_end: assert property (@(posedge clk) disable iff (!arst_n)
    q.txst == LFU_TX_DATA && d.txst == LFU_TX_IDLE |-> q.tx_len == 8'h0 || q_empty)
    else $error("frame cut short");

  a_no_own_reply: assert property (@(posedge clk) disable iff (!arst_n)
    q.txst == LFU_TX_IDLE && q.tx_len == 8'h0 |=> q.txst == LFU_TX_IDLE)
    else $error("transmit without host length");

  a_cmd_enables: assert property (@(posedge clk) disable iff (!arst_n)
    wr && apb_req.paddr == LFU_OFS_CMD && apb_req.pwdata[15:0] == LFU_CMD_LIN
    |=> q.lin && q.resp_ok) else $error("lin not enabled");

  a_lin_needs_cmd: assert property (@(posedge clk) disable iff (!arst_n)
    !q.lin && !(wr && apb_req.paddr == LFU_OFS_CMD && apb_req.pwdata[15:0] == LFU_CMD_LIN)
    |=> !q.lin) else $error("lin mode without command");

  a_resp_value: assert property (@(posedge clk) disable iff (!arst_n)
    rd && apb_req.paddr == LFU_OFS_RESP0 && q.resp_ok |=> q.prdata == LFU_RESP0_VAL)
    else $error("bad confirmation");

  a_sync_dropped: assert property (@(posedge clk) disable iff (!arst_n)
    rx_done && q.rxst == LFU_RX_SYNC && rx_char == LFU_SYNC_BYTE && !q.rxvalid
    |=> !q.rxvalid) else $error("sync byte passed on");

  a_rx_break_silent: assert property (@(posedge clk) disable iff (!arst_n)
    q.rxbusy && q.rxbit > 4'd9 |-> !rx_done) else $error("break taken as byte");

  a_pass_delivers: assert property (@(posedge clk) disable iff (!arst_n)
    rx_done && q.rxst != LFU_RX_SYNC |=> q.rxvalid && q.rxbyte == $past(rx_char))
    else $error("received byte lost");

  a_baud_used: assert property (@(posedge clk) disable iff (!arst_n)
    wr && apb_req.paddr == LFU_OFS_BAUD && apb_req.pwdata != 32'h0
    |=> ##1 q.div == 16'(LFU_CLK_HZ / $past(apb_req.pwdata, 2)))
    else $error("baud not applied");

  a_break_to_sync: assert property (@(posedge clk) disable iff (!arst_n)
    q.lin && q.rxbusy && !d.rxbusy && q.brk_seen |=> q.rxst == LFU_RX_SYNC)
    else $error("break not recognised");

  a_one_wait: assert property (@(posedge clk) disable iff (!arst_n)
    acc && !apb_rsp.pready |=> apb_rsp.pready) else $error("apb answer late");

  a_status_lin: assert property (@(posedge clk) disable iff (!arst_n)
    rd && apb_req.paddr == LFU_OFS_STATUS |=> q.prdata[0] == $past(q.lin))
    else $error("status lin bit wrong");
endmodule // lfu_top

/* File: design/lfu_pkg.sv */
// lfu_pkg: constants, register map and carrier types of the lin framing uart
// assumes an apb slave at 20 MHz and 8n1 character framing on the serial pins
// Behaviour
// - in lin mode each transmit frame starts with a break then a sync byte.
// - receive recognises a thirteen bit break and a 0x55 sync field.
// - in lin mode break and sync byte never reach the receive data.
// - writing 0x3000 to the command entry switches lin framing on.
// - after activation the response reads 01 00 00 then ascii LIN.
// - lin mode is lost at reset; host rewrites the command each startup.
// - the explicit baud rate entry sets bit timing, 10417 accepted.
// - control and status handling unchanged in lin mode.
// - as master the block sends the header then receives the response.
// - as slave the block receives master frames but never answers in slot.
package lfu_pkg;
  localparam logic [11:0] LFU_OFS_CMD    = 12'h000;  // command entry, sub 01
  localparam logic [11:0] LFU_OFS_RESP0  = 12'h004;  // response bytes 0..3
  localparam logic [11:0] LFU_OFS_RESP1  = 12'h008;  // response bytes 4..5
  localparam logic [11:0] LFU_OFS_BAUD   = 12'h00C;  // explicit baud rate
  localparam logic [11:0] LFU_OFS_TXDATA = 12'h010;  // write: queue byte
  localparam logic [11:0] LFU_OFS_TXCTL  = 12'h014;  // write: frame length
  localparam logic [11:0] LFU_OFS_RXDATA = 12'h018;  // read pops byte
  localparam logic [11:0] LFU_OFS_STATUS = 12'h01C;
  localparam logic [15:0] LFU_CMD_LIN    = 16'h3000;
  localparam logic [31:0] LFU_RESP0_VAL  = 32'h4C00_0001;  // 01 00 00 4C
  localparam logic [31:0] LFU_RESP1_VAL  = 32'h0000_4E49;  // 49 4E
  localparam logic [31:0] LFU_BAUD_RST   = 32'h0000_2580;  // 9600 baud
  localparam int          LFU_CLK_HZ     = 20000000;
  localparam logic [7:0]  LFU_SYNC_BYTE  = 8'h55;
  localparam int          LFU_BRK_BITS   = 13;
  localparam int          LFU_BRK_RXMIN  = 11;  // tolerant threshold on receive
  localparam logic [5:0]  LFU_TXQ_DEPTH  = 6'h20;

  typedef enum logic [2:0] {LFU_TX_IDLE, LFU_TX_BREAK, LFU_TX_DELIM, LFU_TX_SYNC,
                            LFU_TX_DATA} lfu_txst_t;
  typedef enum logic [1:0] {LFU_RX_NORM, LFU_RX_SYNC, LFU_RX_PASS} lfu_rxst_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lfu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lfu_apb_rsp_t;
endpackage

/* File: tb/lfu_slave_model.sv */
// lfu_slave_model: behavioural lin slave node seen through a level converter
// assumes idle-high lines with a pull-up and a fixed bit time in ns
`timescale 1ns/1ps
module lfu_slave_model #(
  parameter int BIT_NS = 1000
) (
  input  wire logic bus_in,
  output      logic bus_out
);
  int got[$];  // a byte, or 256 plus break length in bits

  initial bus_out = 1'b1;  // pull-up holds the line high when released

  task automatic send(input bit brk, input logic [7:0] b);  // 8n1 only
    #7;  // off the clock edge, the rx input has no synchroniser
    if (brk) begin
      bus_out = 1'b0;
      #(13 * BIT_NS);
      bus_out = 1'b1;
      #(BIT_NS);
    end
    bus_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      bus_out = b[i];
      #(BIT_NS);
    end
    bus_out = 1'b1;
    #(BIT_NS);
  endtask

  // low still present at the stop position after eight low data bits means a break, length kept
  always begin : rx_dec
    logic [7:0] c;
    realtime    t0;
    @(negedge bus_in);
    t0 = $realtime;
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      c[i] = bus_in;
    end
    #(BIT_NS);
    if (bus_in === 1'b0 && c === 8'h00) begin
      wait (bus_in === 1'b1);
      got.push_back(256 + int'(($realtime - t0) / BIT_NS));
    end else begin
      got.push_back(int'(c));
    end
  end
endmodule // lfu_slave_model

/* File: tb/lfu_top_tb.sv */
// lfu_top_tb: self-checking bench for the lin framing uart over apb
// assumes 20 MHz clock and baud 1000000, so one bit is 20 cycles
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_tests++; if ((sn) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, sn); end end
module lfu_top_tb;
  import lfu_pkg::*;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  lfu_apb_req_t apb_req = '0;
  lfu_apb_rsp_t apb_rsp;
  logic         rxd;
  logic         txd;
  logic [31:0]  rd;
  logic         se;
  int           errors = 0;
  int           n_tests = 0;

  always #25 clk = ~clk;

  lfu_top #(.QW(5)) u_dut (.clk(clk), .arst_n(arst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rxd(rxd), .txd(txd));
  lfu_slave_model #(.BIT_NS(1000)) u_slv (.bus_in(txd), .bus_out(rxd));

  task automatic end_of_test();
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one transfer; answer and read data are taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (apb_rsp.pready !== 1'b1 && t < 50);
    if (apb_rsp.pready !== 1'b1) begin
      errors++;
      $display("CHECK FAILED pready exp 1 got %b", apb_rsp.pready);
    end
    se = apb_rsp.pslverr;
    rd = apb_rsp.prdata;
    apb_req <= '0;
    @(posedge clk);
  endtask

  task automatic t_reset_state();
    `CHK("txd idle", 1'b1, txd)
    apb(1'b0, LFU_OFS_STATUS, 32'h0);
    `CHK("status", 32'h0000_0004, rd)
    apb(1'b0, LFU_OFS_CMD, 32'h0);
    `CHK("cmd", 32'h0000_0000, rd)
    apb(1'b0, LFU_OFS_BAUD, 32'h0);
    `CHK("baud", 32'h0000_2580, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 1'b1, se)
  endtask

  task automatic t_setup();
    apb(1'b1, LFU_OFS_BAUD, 32'h0000_28B1); // no flow control to switch off
    apb(1'b0, LFU_OFS_BAUD, 32'h0);
    `CHK("baud lin", 32'h0000_28B1, rd)
    apb(1'b1, LFU_OFS_BAUD, 32'h000F_4240);
    apb(1'b0, LFU_OFS_BAUD, 32'h0);
    `CHK("baud set", 32'h000F_4240, rd)
  endtask

  // queue bytes, start the frame, compare what the slave decoded
  task automatic tx_frame(input logic [7:0] b[$], input int ex[$]);
    int t;
    u_slv.got.delete();
    foreach (b[i]) apb(1'b1, LFU_OFS_TXDATA, {24'h0, b[i]});
    apb(1'b1, LFU_OFS_TXCTL, 32'(b.size()));
    `CHK("tx start", 1'b0, se)
    t = 0;
    while (u_slv.got.size() < ex.size() && t < 20000) begin
      @(posedge clk);
      t++;
    end
    `CHK("tx count", ex.size(), u_slv.got.size())
    foreach (ex[i]) `CHK("tx item", ex[i], u_slv.got[i])
  endtask

  task automatic t_activate();
    apb(1'b1, LFU_OFS_CMD, 32'h0000_3000);
    `CHK("cmd err", 1'b0, se)
    apb(1'b0, LFU_OFS_CMD, 32'h0);
    `CHK("lin on", 1'b1, rd[0])
    apb(1'b0, LFU_OFS_RESP0, 32'h0);
    `CHK("resp0", 32'h4C00_0001, rd)
    apb(1'b0, LFU_OFS_RESP1, 32'h0);
    `CHK("resp1", 32'h0000_4E49, rd)
  endtask

  // slave answer without break, then a master frame with break and sync
  // send returns between edges; realign before the next bus request
  task automatic t_rx();
    u_slv.send(1'b0, 8'hEA);
    @(posedge clk);
    apb(1'b0, LFU_OFS_RXDATA, 32'h0);
    `CHK("rx resp", 32'h0000_01EA, rd)
    u_slv.send(1'b1, 8'h55);
    @(posedge clk);
    apb(1'b0, LFU_OFS_RXDATA, 32'h0);
    `CHK("sync dropped", 1'b0, rd[8])
    u_slv.send(1'b0, 8'h47);
    @(posedge clk);
    apb(1'b0, LFU_OFS_RXDATA, 32'h0);
    `CHK("rx pid", 32'h0000_0147, rd)
  endtask

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset_state();
    t_setup();
    tx_frame({8'hA5}, {32'hA5});
    t_activate();
    tx_frame({8'h47}, {269, 85, 71});
    tx_frame({8'h47, 8'hEA, 8'hBD, 8'h08, 8'hB7, 8'h97},
      {269, 85, 71, 234, 189, 8, 183, 151}); // pid and checksum from host
    t_rx();
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset_state();
    end_of_test();
  end

  // the sequence needs well under 1 ms; twice that means a hang
  initial begin
    #2_000_000;
    errors++;
    end_of_test();
  end
endmodule // lfu_top_tb
